/* core/drd_pkg.sv */
`default_nettype none
package drd_pkg;
   localparam int          DATA_W          = 8;
   localparam int          REG_N           = 16;
   localparam int          RNUM_W          = 4;
   // Channel select encoding
   localparam logic        CH_A            = 1'b1;
   localparam logic        CH_B            = 1'b0;
   // Command register fields
   localparam int          PTR_LSB         = 0;
   localparam int          CMD_LSB         = 3;
   localparam logic [2:0]  CMD_POINT_HIGH  = 3'h1;
   localparam logic [3:0]  BANK_HIGH_OFS   = 4'h8;
   // Bus address fields
   localparam int          BUS_RNUM_LSB    = 1;
   localparam int          BUS_SEL_RIGHT   = 0;
   localparam int          BUS_SEL_LEFT    = 5;
   // Option bits
   localparam int          STAT_FIFO_BIT   = 2;
   localparam int          EXT_READ_BIT    = 6;
   // Register numbers, reset value and read source select
   localparam logic [3:0]  R_CMD           = 4'h0;
   localparam logic [3:0]  R_VECTOR        = 4'h2;
   localparam logic [3:0]  R_RX_PARAM      = 4'h3;
   localparam logic [3:0]  R_MISC_MODE     = 4'h4;
   localparam logic [3:0]  R_TX_PARAM      = 4'h5;
   localparam logic [3:0]  R_MASTER_INT    = 4'h9;
   localparam logic [3:0]  R_MISC_TX_RX    = 4'ha;
   localparam logic [3:0]  R_AUX           = 4'he;
   localparam logic [3:0]  R_EXT_INT       = 4'hf;
   localparam logic [3:0]  RD_BAUD_HIGH    = 4'hd;
   localparam logic [3:0]  RD_EXT_INT      = 4'hf;
   localparam logic [7:0]  RST_VAL         = 8'h00;
   typedef enum logic [1:0] {
      DRD_SRC_RR,
      DRD_SRC_WR,
      DRD_SRC_AUX
   } drd_src_t;
endpackage
`default_nettype wire

/* core/drd_wr_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface drd_wr_if;
   logic                 we;
   logic                 ch;
   logic [3:0]           wnum;
   logic [7:0]           wdata;
   logic                 rch;
   logic [3:0]           rnum;
   logic [7:0]           rdata;
   modport ctrl (output we, ch, wnum, wdata, rch, rnum, input rdata);
   modport mem  (input we, ch, wnum, wdata, rch, rnum, output rdata);
endinterface
`default_nettype wire

/* core/drd_wr_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// Write-register storage, one copy per channel; read data registered.
module drd_wr_mem (
   input  wire logic     clock,
   input  wire logic     sys_rst,
   drd_wr_if.mem         port
);
   logic [7:0] mem_q [0:1][0:15];
   logic [7:0] mem_d [0:1][0:15];
   logic [7:0] rd_q;
   logic [7:0] rd_d;

   always_comb begin
      mem_d = mem_q;
      if (port.we) begin
         mem_d[port.ch][port.wnum] = port.wdata;
      end
      rd_d = mem_q[port.rch][port.rnum];
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int c = 0; c < 2; c++) begin
            for (int r = 0; r < 16; r++) begin
               mem_q[c][r] <= drd_pkg::RST_VAL;
            end
         end
         rd_q <= drd_pkg::RST_VAL;
      end else begin
         mem_q <= mem_d;
         rd_q  <= rd_d;
      end
   end

   assign port.rdata = rd_q;
endmodule // drd_wr_mem
`default_nettype wire

/* core/drd_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - In pointer mode the low three command-register bits pick register 0-7.
// - The point-high command adds eight so the pointer reaches 8-15.
// - Without status FIFO, reads 4-7 alias 0-3 and 9, 11 read 13, 15.
// - Status FIFO bit in ext_int_control_reg makes 6 and 7 read themselves.
// - FIFO plus extended read show write regs 4, 5, 3, 10 and aux feature.
// - Shift-right takes number from lines 4..1 and channel from line 0.
// - Reset forces shift-left; channel from line 5, lines 7 and 6 ignored.
// - Vector and master interrupt registers exist once for both channels.
// - Decode mode is a single flag for both channels, changed only by command or reset.
module drd_decode (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        ptr_mode,
   input  wire logic        acc_valid,
   input  wire logic        acc_write,
   input  wire logic [7:0]  bus_addr,
   input  wire logic        ptr_ch,
   input  wire logic [7:0]  wdata,
   input  wire logic        shift_cmd_valid,
   input  wire logic        shift_right_set,
   input  wire logic [7:0]  rr_data_a,
   input  wire logic [7:0]  rr_data_b,
   output logic             rd_valid,
   output logic [7:0]       rdata,
   output logic             rr_ch,
   output logic [3:0]       rr_num,
   output logic             shift_right,
   output logic [2:0]       reg_pointer,
   output logic             point_high
);
   drd_wr_if wr ();

   logic             shr_q, shr_d;
   logic [2:0]       ptr_q, ptr_d;
   logic             ph_q, ph_d;
   logic [7:0]       vec_q, vec_d;
   logic [7:0]       mic_q, mic_d;
   logic [7:0]       eic_q [0:1];
   logic [7:0]       eic_d [0:1];
   logic [7:0]       aux_q [0:1];
   logic [7:0]       aux_d [0:1];
   logic             rv_q, rv_d;
   drd_pkg::drd_src_t src_q, src_d;
   logic [7:0]       sh_q, sh_d;
   logic             ch;
   logic [3:0]       num;
   logic [3:0]       rnum;
   drd_pkg::drd_src_t src;
   logic [7:0]       shared_v;
   logic             fifo_en, ext_en;

   // Register number from the current pointer state
   function automatic logic [3:0] ptr_num(input logic [2:0] p, input logic h);
      ptr_num = {1'b0, p} + (h ? drd_pkg::BANK_HIGH_OFS : 4'h0);
   endfunction

   always_comb begin
      if (ptr_mode) begin
         ch  = ptr_ch;
         num = ptr_num(ptr_q, ph_q);
      end else if (shr_q) begin
         ch  = bus_addr[drd_pkg::BUS_SEL_RIGHT];
         num = bus_addr[drd_pkg::BUS_RNUM_LSB +: 4];
      end else begin
         ch  = bus_addr[drd_pkg::BUS_SEL_LEFT];
         num = bus_addr[drd_pkg::BUS_RNUM_LSB +: 4];
      end
   end

   // Read remap; channel index 1 is channel A
   always_comb begin
      fifo_en = eic_q[ch][drd_pkg::STAT_FIFO_BIT];
      ext_en  = fifo_en && aux_q[ch][drd_pkg::EXT_READ_BIT];
      rnum    = num;
      src     = drd_pkg::DRD_SRC_RR;
      shared_v = 8'h00;
      case (num)
         4'h4, 4'h5: begin
            if (ext_en) begin
               src = drd_pkg::DRD_SRC_WR;
            end else begin
               rnum = num - 4'h4;
            end
         end
         4'h6, 4'h7: begin
            if (!fifo_en) begin
               rnum = num - 4'h4;
            end
         end
         4'h9: begin
            if (ext_en) begin
               src  = drd_pkg::DRD_SRC_WR;
               rnum = drd_pkg::R_RX_PARAM;
            end else begin
               rnum = drd_pkg::RD_BAUD_HIGH;
            end
         end
         4'hb: begin
            if (ext_en) begin
               src  = drd_pkg::DRD_SRC_WR;
               rnum = drd_pkg::R_MISC_TX_RX;
            end else begin
               rnum = drd_pkg::RD_EXT_INT;
            end
         end
         4'he: begin
            if (ext_en) begin
               src = drd_pkg::DRD_SRC_AUX;
            end
         end
         default: begin
            rnum = num;
         end
      endcase
      if (rnum == drd_pkg::R_VECTOR) begin
         shared_v = vec_q;
      end
   end

   assign wr.we    = acc_valid && acc_write;
   assign wr.ch    = ch;
   assign wr.wnum  = num;
   assign wr.wdata = wdata;
   assign wr.rch   = ch;
   assign wr.rnum  = rnum;

   drd_wr_mem u_mem (
      .clock   (clock),
      .sys_rst (sys_rst),
      .port    (wr)
   );

   always_comb begin
      shr_d = shr_q;
      ptr_d = ptr_q;
      ph_d  = ph_q;
      vec_d = vec_q;
      mic_d = mic_q;
      eic_d = eic_q;
      aux_d = aux_q;
      if (shift_cmd_valid) begin
         shr_d = shift_right_set;
      end
      if (acc_valid) begin
         ptr_d = 3'h0;
         ph_d  = 1'b0;
      end
      if (acc_valid && acc_write) begin
         case (num)
            drd_pkg::R_CMD: begin
               // Command register write sets the pointer for next access
               ptr_d = wdata[drd_pkg::PTR_LSB +: 3];
               ph_d  = (wdata[drd_pkg::CMD_LSB +: 3]
                        == drd_pkg::CMD_POINT_HIGH);
            end
            drd_pkg::R_VECTOR:     vec_d = wdata;
            drd_pkg::R_MASTER_INT: mic_d = wdata;
            drd_pkg::R_EXT_INT:    eic_d[ch] = wdata;
            drd_pkg::R_AUX: begin
               // Aux shares the slot; written only with bit 0 of ext
               if (eic_q[ch][0]) begin
                  aux_d[ch] = wdata;
               end
            end
            default: ;
         endcase
      end
      rv_d  = acc_valid && !acc_write;
      src_d = src;
      sh_d  = (src == drd_pkg::DRD_SRC_AUX) ? aux_q[ch] : shared_v;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         shr_q <= 1'b0;
         ptr_q <= 3'h0;
         ph_q  <= 1'b0;
         vec_q <= drd_pkg::RST_VAL;
         mic_q <= drd_pkg::RST_VAL;
         eic_q <= '{default: drd_pkg::RST_VAL};
         aux_q <= '{default: drd_pkg::RST_VAL};
         rv_q  <= 1'b0;
         src_q <= drd_pkg::DRD_SRC_RR;
         sh_q  <= drd_pkg::RST_VAL;
      end else begin
         shr_q <= shr_d;
         ptr_q <= ptr_d;
         ph_q  <= ph_d;
         vec_q <= vec_d;
         mic_q <= mic_d;
         eic_q <= eic_d;
         aux_q <= aux_d;
         rv_q  <= rv_d;
         src_q <= src_d;
         sh_q  <= sh_d;
      end
   end

   // Live status sampled in the access cycle, presented next cycle
   logic [7:0] rr_q, rr_d;
   always_comb begin
      rr_d = (ch == drd_pkg::CH_A) ? rr_data_a : rr_data_b;
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rr_q <= drd_pkg::RST_VAL;
      end else begin
         rr_q <= rr_d;
      end
   end

   always_comb begin
      case (src_q)
         drd_pkg::DRD_SRC_WR:  rdata = wr.rdata;
         drd_pkg::DRD_SRC_AUX: rdata = sh_q;
         default:              rdata = rr_q;
      endcase
   end

   assign rd_valid    = rv_q;
   assign rr_ch       = ch;
   assign rr_num      = rnum;
   assign shift_right = shr_q;
   assign reg_pointer = ptr_q;
   assign point_high  = ph_q;
endmodule // drd_decode
`default_nettype wire

/* test/drd_decode_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module drd_decode_chk (
   input wire logic       clock,
   input wire logic       sys_rst,
   input wire logic       ptr_mode,
   input wire logic       acc_valid,
   input wire logic       acc_write,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] wdata,
   input wire logic       shift_cmd_valid,
   input wire logic       shift_right_set,
   input wire logic       rd_valid,
   input wire logic       rr_ch,
   input wire logic [3:0] rr_num,
   input wire logic       shift_right,
   input wire logic [2:0] reg_pointer,
   input wire logic       point_high
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_rd; acc_valid && !acc_write; endsequence
   sequence s_cmd; ptr_mode && acc_valid && acc_write && !point_high
      && reg_pointer == 3'h0; endsequence
   property p_rd; s_rd |=> rd_valid; endproperty
   a_rd: assert property (p_rd) else $error("no read data");
   property p_rst; disable iff (1'b0) sys_rst |=> !shift_right; endproperty
   a_rst: assert property (p_rst) else $error("not left");
   property p_left; acc_valid && !ptr_mode && !shift_right
      |-> rr_ch == bus_addr[5]; endproperty
   a_left: assert property (p_left) else $error("left chan");
   property p_right; acc_valid && !ptr_mode && shift_right
      |-> rr_ch == bus_addr[0]; endproperty
   a_right: assert property (p_right) else $error("right chan");
   property p_hi; acc_valid && !acc_write && ptr_mode && point_high
      && reg_pointer inside {3'h0, 3'h2, 3'h4, 3'h5, 3'h7}
      |-> rr_num == {1'b1, reg_pointer}; endproperty
   a_hi: assert property (p_hi) else $error("high bank");
   property p_cmd; s_cmd |=> reg_pointer == $past(wdata[2:0])
      && point_high == ($past(wdata[5:3]) == 3'h1); endproperty
   a_cmd: assert property (p_cmd) else $error("pointer load");
   property p_clr; ptr_mode && acc_valid && !(acc_write && !point_high
      && reg_pointer == 3'h0) |=> reg_pointer == 3'h0 && !point_high;
   endproperty
   a_clr: assert property (p_clr) else $error("pointer kept");
   property p_sh; shift_cmd_valid |=> shift_right == $past(shift_right_set);
   endproperty
   a_sh: assert property (p_sh) else $error("mode cmd");
endmodule // drd_decode_chk
bind drd_decode drd_decode_chk u_chk (.clock(clock), .sys_rst(sys_rst),
   .ptr_mode(ptr_mode), .acc_valid(acc_valid), .acc_write(acc_write),
   .bus_addr(bus_addr), .wdata(wdata), .shift_cmd_valid(shift_cmd_valid),
   .shift_right_set(shift_right_set), .rd_valid(rd_valid), .rr_ch(rr_ch),
   .rr_num(rr_num), .shift_right(shift_right), .reg_pointer(reg_pointer),
   .point_high(point_high));
`default_nettype wire

/* test/drd_chan_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Value carries channel and number, so any wrong remap shows in the data
module drd_chan_model (
   input  wire logic [3:0] rr_num,
   output logic      [7:0] rr_data_a,
   output logic      [7:0] rr_data_b
);
   assign rr_data_a = {3'h5, 1'b1, rr_num};
   assign rr_data_b = {3'h5, 1'b0, rr_num};
endmodule // drd_chan_model
`default_nettype wire

/* test/drd_decode_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module drd_decode_tb;
   logic       clock = 1'b0;
   logic       sys_rst = 1'b1;
   logic       ptr_mode = 1'b0;
   logic       acc_valid = 1'b0;
   logic       acc_write = 1'b0;
   logic       ptr_ch = 1'b0;
   logic       shift_cmd_valid = 1'b0;
   logic       shift_right_set = 1'b0;
   logic [7:0] bus_addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       rd_valid, rr_ch, shift_right, point_high, sr;
   logic [7:0] rdata, rr_data_a, rr_data_b;
   logic [3:0] rr_num;
   logic [2:0] reg_pointer;
   logic [7:0] wr [2][16];
   logic [7:0] aux [2];
   logic [7:0] q [$];
   int         bad_count = 0;
   int         compares = 0;

   drd_decode dut (.clock(clock), .sys_rst(sys_rst), .ptr_mode(ptr_mode),
      .acc_valid(acc_valid), .acc_write(acc_write), .bus_addr(bus_addr),
      .ptr_ch(ptr_ch), .wdata(wdata), .shift_cmd_valid(shift_cmd_valid),
      .shift_right_set(shift_right_set), .rr_data_a(rr_data_a),
      .rr_data_b(rr_data_b), .rd_valid(rd_valid), .rdata(rdata),
      .rr_ch(rr_ch), .rr_num(rr_num), .shift_right(shift_right),
      .reg_pointer(reg_pointer), .point_high(point_high));
   drd_chan_model u_chan (.rr_num(rr_num), .rr_data_a(rr_data_a),
      .rr_data_b(rr_data_b));

   always #5 clock = ~clock;

   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      compares++;
      if (seen !== want) begin
         bad_count++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic close_out;
      $display("mismatches %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   function automatic logic [7:0] exp_rd(input logic c, input logic [3:0] n);
      logic       f, e;
      logic [3:0] m;
      f = wr[c][15][2];
      e = f & aux[c][6];
      m = n;
      if (e && (n == 4'h4 || n == 4'h5)) return wr[c][n];
      if (e && n == 4'h9) return wr[c][3];
      if (e && n == 4'hb) return wr[c][10];
      if (e && n == 4'he) return aux[c];
      if (n inside {4'h4, 4'h5} || (!f && n inside {4'h6, 4'h7}))
         m = n - 4'h4;
      if (n == 4'h9) m = 4'hd;
      if (n == 4'hb) m = 4'hf;
      return {3'h5, c, m};
   endfunction

   // Unused address lines get random junk so decode must ignore them
   task automatic acc(input logic w, input logic c, input logic [3:0] n,
                      input logic [7:0] d);
      logic [7:0] r;
      r = 8'($urandom);
      acc_valid <= 1'b1;
      acc_write <= w;
      wdata <= d;
      ptr_ch <= c;
      bus_addr <= sr ? {r[7:5], n, c} : {r[7:6], c, n, r[0]};
      if (!w)
         q.push_back(exp_rd(c, n));
      else if (n == 4'he && wr[c][15][0])
         aux[c] = d;
      else
         wr[c][n] = d;
      @(posedge clock);
   endtask

   task automatic sweep;
      for (int c = 0; c < 2; c++)
         for (int n = 0; n < 16; n++)
            acc(1'b0, c[0], n[3:0], 8'h00);
   endtask

   // Dedicated mode command; bus idle while it is given
   task automatic set_mode(input logic v);
      acc_valid <= 1'b0;
      shift_cmd_valid <= 1'b1;
      shift_right_set <= v;
      @(posedge clock);
      shift_cmd_valid <= 1'b0;
      sr = v;
      #1 chk({7'h0, shift_right}, {7'h0, v});
      @(posedge clock);
   endtask

   task automatic do_reset;
      sys_rst <= 1'b1;
      acc_valid <= 1'b0;
      ptr_mode <= 1'b0;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      sr = 1'b0;
      foreach (wr[i, j]) wr[i][j] = 8'h00;
      aux = '{8'h00, 8'h00};
      #1 chk({7'h0, shift_right}, 8'h00);
   endtask

   always @(posedge clock) begin
      if (rd_valid === 1'b1) begin
         if (q.size() == 0)
            chk({7'h0, rd_valid}, 8'h00);
         else
            chk(rdata, q.pop_front());
      end
   end

   initial begin
      #200000;
      bad_count++;
      close_out();
   end

   initial begin
      void'($urandom(32'h2de3));
      do_reset();
      @(posedge clock);
      sweep();
      acc(1'b1, 1'b1, 4'hf, 8'h05);
      sweep();
      for (int c = 0; c < 2; c++)
         for (int n = 0; n < 16; n++)
            if (n inside {3, 4, 5, 10})
               acc(1'b1, c[0], n[3:0], 8'($urandom));
      acc(1'b1, 1'b0, 4'he, 8'hff);
      acc(1'b1, 1'b1, 4'he, 8'($urandom) | 8'h40);
      sweep();
      set_mode(1'b1);
      sweep();
      set_mode(1'b0);
      sweep();
      set_mode(1'b1);
      ptr_mode <= 1'b1;
      for (int c = 0; c < 2; c++)
         for (int p = 0; p < 16; p++) begin
            acc(1'b1, c[0], 4'h0, {2'b00, 2'b00, p[3], p[2:0]});
            acc(1'b0, c[0], p[3:0], 8'h00);
         end
      acc(1'b0, 1'b1, 4'h0, 8'h00);
      do_reset();
      @(posedge clock);
      sweep();
      acc_valid <= 1'b0;
      repeat (3) @(posedge clock);
      chk(8'(q.size()), 8'h00);
      close_out();
   end
endmodule // drd_decode_tb
`default_nettype wire
